// File: rtl/quad_decoder.sv
// Quadrature decoder with periodic sampling, accumulators and illumination output
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`include "quad_decoder_cfg.svh"

// Overview of operation
// - While running, sample phases once per programmed sample period.
// - Sample continuously after start, comparing each pair with the previous pair.
// - Unchanged pair reports zero and leaves both accumulators alone.
// - Forward gray step reports one and increments the movement accumulator.
// - Reverse gray step reports minus one and decrements the movement accumulator.
// - Both phases changing reports two and bumps the double-transition counter only.
// - Illumination turns on lead time before sampling, off right after it.
// - Illumination active level follows the polarity setting.
// - Disconnected illumination selection leaves the illumination pin undriven.
// - Movement accumulator adds valid steps and ignores double transitions.
// - Each new sample value raises a sample-ready event.
module quad_decoder
    import quad_decoder_pkg::*;
#(
    parameter int ACC_W = 16,
    parameter int DBL_W = 8,
    parameter int PER_W = 16
) (
    // Clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        NRST_I,
    // Avalon-MM slave
    input  wire logic [11:0] AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output      logic [31:0] AVS_READDATA_O,
    output      logic        AVS_WAITREQUEST_O,
    // Interrupt
    output      logic        IRQ_O,
    // Encoder pins
    input  wire logic        PHASE_A_I,
    input  wire logic        PHASE_B_I,
    output      logic        ILLUM_O,
    output      logic        ILLUM_OE_N_O
);

    localparam int TICK_CYC = `QD_TICK_CYC;

    quad_link_if link ();

    run_type                   state;
    logic                      enable;
    logic                      polarity;
    logic                      illum_sel;
    logic [PER_W-1:0]          period;
    logic [PER_W-1:0]          lead;
    logic [PER_W-1:0]          per_cnt;
    logic [7:0]                pre_cnt;
    motion_type                sample_val;
    logic signed [ACC_W-1:0]   acc;
    logic signed [ACC_W-1:0]   acc_snap;
    logic [DBL_W-1:0]          dbl;
    logic [DBL_W-1:0]          dbl_snap;
    logic [`QD_EVT_W-1:0]      evt;
    logic [`QD_EVT_W-1:0]      mask;
    logic [31:0]               rd_val;
    logic                      wr_go;
    logic                      illum_on;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic wr_hit(input logic [11:0] ofs);
        return wr_go && (AVS_ADDRESS_I == ofs) && AVS_WRITEDATA_I[0] && AVS_BYTEENABLE_I[0];
    endfunction : wr_hit

    function automatic logic [PER_W-1:0] merge(input logic [PER_W-1:0] old, input logic [31:0] d);
        logic [PER_W-1:0] r;
        r = old;
        for (int i = 0; i < PER_W; i++) begin
            if (AVS_BYTEENABLE_I[i / 8])
                r[i] = d[i];
        end
        return r;
    endfunction : merge

    function automatic logic cfg_hit(input logic [11:0] ofs);
        return wr_go && (AVS_ADDRESS_I == ofs);
    endfunction : cfg_hit

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // One wait cycle: the access completes at the second edge of the request
    assign wr_go = AVS_WRITE_I && !AVS_WAITREQUEST_O;

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O    <= 32'h0;
        end else begin
            AVS_WAITREQUEST_O <= 1'b1;
            if ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O)
                AVS_WAITREQUEST_O <= 1'b0;
            if (AVS_READ_I && AVS_WAITREQUEST_O)
                AVS_READDATA_O <= rd_val;
        end
    end

    always_comb begin
        rd_val = 32'h0;
        case (AVS_ADDRESS_I)
            `QD_OFS_ENABLE:    rd_val = {31'h0, enable};
            `QD_OFS_POLARITY:  rd_val = {31'h0, polarity};
            `QD_OFS_PERIOD:    rd_val = 32'(period);
            `QD_OFS_SAMPLE:    rd_val = (sample_val == MOV_REV) ? 32'hFFFFFFFF : {30'h0, sample_val};
            `QD_OFS_ACC:       rd_val = 32'(acc);
            `QD_OFS_ACC_SNAP:  rd_val = 32'(acc_snap);
            `QD_OFS_ILLUM_SEL: rd_val = {31'h0, illum_sel};
            `QD_OFS_LEAD:      rd_val = 32'(lead);
            `QD_OFS_DBL:       rd_val = 32'(dbl);
            `QD_OFS_DBL_SNAP:  rd_val = 32'(dbl_snap);
            `QD_OFS_STATUS:    rd_val = 32'(evt);
            `QD_OFS_MASK:      rd_val = 32'(mask);
            default:           rd_val = 32'h0;
        endcase
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Period and lead are plain stores; changing them while running is undefined
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            enable    <= 1'b0;
            polarity  <= `QD_RST_POLARITY;
            illum_sel <= `QD_RST_ILLUM_SEL;
            period    <= PER_W'(`QD_RST_PERIOD);
            lead      <= PER_W'(`QD_RST_LEAD);
            mask      <= '0;
        end else begin
            if (cfg_hit(`QD_OFS_ENABLE) && AVS_BYTEENABLE_I[0])
                enable <= AVS_WRITEDATA_I[0];
            if (cfg_hit(`QD_OFS_POLARITY) && AVS_BYTEENABLE_I[0])
                polarity <= AVS_WRITEDATA_I[0];
            if (cfg_hit(`QD_OFS_ILLUM_SEL) && AVS_BYTEENABLE_I[0])
                illum_sel <= AVS_WRITEDATA_I[0];
            if (cfg_hit(`QD_OFS_PERIOD))
                period <= merge(period, AVS_WRITEDATA_I);
            if (cfg_hit(`QD_OFS_LEAD))
                lead <= merge(lead, AVS_WRITEDATA_I);
            if (cfg_hit(`QD_OFS_MASK) && AVS_BYTEENABLE_I[0])
                mask <= AVS_WRITEDATA_I[`QD_EVT_W-1:0];
        end
    end

    // ----------------------------------------
    // Run state
    // ----------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state        <= ST_IDLE;
            link.restart <= 1'b0;
        end else begin
            link.restart <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (wr_hit(`QD_OFS_START) && enable) begin
                        state        <= ST_RUN;
                        link.restart <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (wr_hit(`QD_OFS_STOP) || !enable)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Sample timing
    // ----------------------------------------
    // Period and lead count in 1 us ticks; a zero period acts as one tick
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pre_cnt         <= 8'h0;
            per_cnt         <= '0;
            link.sample_stb <= 1'b0;
        end else begin
            link.sample_stb <= 1'b0;
            if (state != ST_RUN || link.restart) begin
                pre_cnt <= 8'h0;
                per_cnt <= (period == '0) ? PER_W'(1) : period;
            end else if (pre_cnt == 8'(TICK_CYC - 1)) begin
                pre_cnt <= 8'h0;
                if (per_cnt <= PER_W'(1)) begin
                    per_cnt         <= (period == '0) ? PER_W'(1) : period;
                    link.sample_stb <= 1'b1;
                end else begin
                    per_cnt <= per_cnt - PER_W'(1);
                end
            end else begin
                pre_cnt <= pre_cnt + 8'h1;
            end
        end
    end

    // ----------------------------------------
    // Illumination output
    // ----------------------------------------
    // Lead not shorter than the period keeps the light on continuously
    always_comb begin
        illum_on = (state == ST_RUN) && !link.restart && (lead != '0) && (per_cnt <= lead);
        if (pre_cnt == 8'(TICK_CYC - 1) && per_cnt <= PER_W'(1) && lead < period)
            illum_on = 1'b0;
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ILLUM_O      <= 1'b0;
            ILLUM_OE_N_O <= 1'b1;
        end else begin
            ILLUM_O      <= polarity ? illum_on : !illum_on;
            ILLUM_OE_N_O <= !(enable && illum_sel);
        end
    end

    // ----------------------------------------
    // Sampler
    // ----------------------------------------
    phase_sampler u_sampler (
        .clk_i     (SYS_CLK_I),
        .nrst_i    (NRST_I),
        .phase_a_i (PHASE_A_I),
        .phase_b_i (PHASE_B_I),
        .link      (link.samp)
    );

    // ----------------------------------------
    // Accumulators
    // ----------------------------------------
    logic clr_acc;
    logic clr_dbl;
    logic acc_ovf;
    logic dbl_ovf;

    // Helpers read the bus themselves; a continuous assignment would never re-evaluate
    always_comb begin
        clr_acc = wr_hit(`QD_OFS_CLR_BOTH) || wr_hit(`QD_OFS_CLR_ACC);
        clr_dbl = wr_hit(`QD_OFS_CLR_BOTH) || wr_hit(`QD_OFS_CLR_DBL);
    end
    assign acc_ovf = link.value_stb &&
                     ((link.value == MOV_FWD && acc == {1'b0, {(ACC_W-1){1'b1}}}) ||
                      (link.value == MOV_REV && acc == {1'b1, {(ACC_W-1){1'b0}}}));
    assign dbl_ovf = link.value_stb && link.value == MOV_DBL && dbl == '1;

    // A step arriving with a clear is kept on top of the cleared value
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            acc        <= '0;
            acc_snap   <= '0;
            sample_val <= MOV_NONE;
        end else begin
            if (link.value_stb)
                sample_val <= link.value;
            if (clr_acc)
                acc_snap <= acc;
            if (link.value_stb && !acc_ovf && link.value == MOV_FWD)
                acc <= (clr_acc ? '0 : acc) + ACC_W'(1);
            else if (link.value_stb && !acc_ovf && link.value == MOV_REV)
                acc <= (clr_acc ? '0 : acc) - ACC_W'(1);
            else if (clr_acc)
                acc <= '0;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            dbl      <= '0;
            dbl_snap <= '0;
        end else begin
            if (clr_dbl)
                dbl_snap <= dbl;
            if (link.value_stb && link.value == MOV_DBL && !dbl_ovf)
                dbl <= (clr_dbl ? '0 : dbl) + DBL_W'(1);
            else if (clr_dbl)
                dbl <= '0;
        end
    end

    // ----------------------------------------
    // Events and interrupt
    // ----------------------------------------
    logic [`QD_EVT_W-1:0] evt_set;
    logic [`QD_EVT_W-1:0] next_evt;

    always_comb begin
        evt_set                  = '0;
        evt_set[`QD_EVT_RDY]     = link.value_stb;
        evt_set[`QD_EVT_STOPPED] = (state == ST_RUN) && (wr_hit(`QD_OFS_STOP) || !enable);
        evt_set[`QD_EVT_OVF]     = acc_ovf || dbl_ovf;
        evt_set[`QD_EVT_DBL]     = link.value_stb && link.value == MOV_DBL;
        next_evt                 = evt;
        if (cfg_hit(`QD_OFS_STATUS) && AVS_BYTEENABLE_I[0])
            next_evt = evt & ~AVS_WRITEDATA_I[`QD_EVT_W-1:0];
        next_evt = next_evt | evt_set;
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            evt   <= '0;
            IRQ_O <= 1'b0;
        end else begin
            evt   <= next_evt;
            IRQ_O <= |(next_evt & mask);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_SAMPLE_WHILE_RUN: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        link.sample_stb |-> $past(state) == ST_RUN && $past(pre_cnt) == 8'(TICK_CYC - 1))
        else $error("Sample taken outside running or off tick");

    AST_ACC_INC: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        link.value_stb && link.value == MOV_FWD && !acc_ovf && !clr_acc |=> acc == $past(acc) + ACC_W'(1))
        else $error("Accumulator did not increment");

    AST_ACC_DEC: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        link.value_stb && link.value == MOV_REV && !acc_ovf && !clr_acc |=> acc == $past(acc) - ACC_W'(1))
        else $error("Accumulator did not decrement");

    AST_ACC_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        link.value_stb && (link.value == MOV_NONE || link.value == MOV_DBL) && !clr_acc |=> $stable(acc))
        else $error("Accumulator changed without a valid step");

    AST_DBL_COUNT: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        link.value_stb && link.value == MOV_DBL && !dbl_ovf && !clr_dbl |=> dbl == $past(dbl) + DBL_W'(1))
        else $error("Double transition not counted");

    AST_READY_EVENT: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        link.value_stb |=> evt[`QD_EVT_RDY] && sample_val == $past(link.value))
        else $error("Sample ready event missing");

    AST_ILLUM_OFF: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        link.sample_stb && lead < period |-> ILLUM_O == !polarity)
        else $error("Illumination still on after sample");

    AST_ILLUM_RELEASE: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        !illum_sel |=> ILLUM_OE_N_O)
        else $error("Illumination driven while disconnected");

endmodule : quad_decoder

// File: rtl/quad_decoder_cfg.svh
// Register map, field positions, reset values and timing of the quadrature decoder
`ifndef QUAD_DECODER_CFG_SVH
`define QUAD_DECODER_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define QD_ADDR_W        12
`define QD_OFS_START     12'h000
`define QD_OFS_STOP      12'h004
`define QD_OFS_CLR_BOTH  12'h008
`define QD_OFS_CLR_ACC   12'h00C
`define QD_OFS_CLR_DBL   12'h010
`define QD_OFS_ENABLE    12'h500
`define QD_OFS_POLARITY  12'h504
`define QD_OFS_PERIOD    12'h508
`define QD_OFS_SAMPLE    12'h50C
`define QD_OFS_ACC       12'h514
`define QD_OFS_ACC_SNAP  12'h518
`define QD_OFS_ILLUM_SEL 12'h51C
`define QD_OFS_LEAD      12'h540
`define QD_OFS_DBL       12'h544
`define QD_OFS_DBL_SNAP  12'h548
`define QD_OFS_STATUS    12'h600
`define QD_OFS_MASK      12'h604

// ----------------------------------------
// Event bits in status and mask
// ----------------------------------------
`define QD_EVT_W         4
`define QD_EVT_RDY       0
`define QD_EVT_STOPPED   1
`define QD_EVT_OVF       2
`define QD_EVT_DBL       3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define QD_RST_PERIOD    16'h0080
`define QD_RST_LEAD      16'h0010
`define QD_RST_POLARITY  1'h1
`define QD_RST_ILLUM_SEL 1'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define QD_CLK_NS        5
`define QD_TICK_NS       1000
`define QD_TICK_CYC      ((`QD_TICK_NS + `QD_CLK_NS - 1) / `QD_CLK_NS)

`endif

// File: rtl/quad_decoder_pkg.sv
// Types shared by the quadrature decoder modules
package quad_decoder_pkg;

    typedef enum logic [1:0] {
        MOV_NONE = 2'h0,
        MOV_FWD  = 2'h1,
        MOV_DBL  = 2'h2,
        MOV_REV  = 2'h3
    } motion_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } run_type;

endpackage : quad_decoder_pkg

// File: rtl/quad_link_if.sv
// Link between the decoder control logic and the phase sampler
`timescale 1ns/10ps
interface quad_link_if;
    import quad_decoder_pkg::*;

    logic       sample_stb;
    logic       restart;
    motion_type value;
    logic       value_stb;

    modport ctrl (output sample_stb, output restart, input value, input value_stb);
    modport samp (input sample_stb, input restart, output value, output value_stb);
endinterface : quad_link_if

// File: rtl/phase_sampler.sv
// Phase input synchroniser, sample capture and transition decoder
`timescale 1ns/10ps
module phase_sampler
    import quad_decoder_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // Encoder phases
    input  wire logic phase_a_i,
    input  wire logic phase_b_i,
    // Control side
    quad_link_if.samp link
);

    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic       primed;

    // ----------------------------------------
    // Synchroniser
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
        end else begin
            sync1 <= {phase_a_i, phase_b_i};
            sync2 <= sync1;
        end
    end

    // ----------------------------------------
    // Decode of pair against previous pair
    // ----------------------------------------
    function automatic motion_type decode(input logic [1:0] p, input logic [1:0] c);
        logic [1:0] fwd;
        fwd = 2'h0;
        case (p)
            2'b00: fwd = 2'b01;
            2'b01: fwd = 2'b11;
            2'b11: fwd = 2'b10;
            default: fwd = 2'b00;
        endcase
        if (p == c)
            return MOV_NONE;
        else if ((p ^ c) == 2'b11)
            return MOV_DBL;
        else if (c == fwd)
            return MOV_FWD;
        else
            return MOV_REV;
    endfunction : decode

    // First sample after start only primes the previous pair, avoiding a false step
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev           <= 2'h0;
            primed         <= 1'b0;
            link.value     <= MOV_NONE;
            link.value_stb <= 1'b0;
        end else begin
            link.value_stb <= 1'b0;
            if (link.restart) begin
                prev   <= 2'h0;
                primed <= 1'b0;
            end else if (link.sample_stb) begin
                prev           <= sync2;
                primed         <= 1'b1;
                link.value_stb <= 1'b1;
                link.value     <= primed ? decode(prev, sync2) : MOV_NONE;
            end
        end
    end

    AST_DBL_DECODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        link.sample_stb && primed && !link.restart && ((prev ^ sync2) == 2'b11) |=> link.value == MOV_DBL)
        else $error("Double transition not decoded");

    AST_STILL_DECODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        link.sample_stb && !link.restart && prev == sync2 |=> link.value_stb && link.value == MOV_NONE)
        else $error("Unchanged pair not reported as zero");

endmodule : phase_sampler

// File: testbench/quad_encoder_model.sv
// Behavioural incremental encoder driving the two phase lines
`timescale 1ns/10ps
module quad_encoder_model (
    // Clock
    input  wire logic       clk_i,
    // Target pair {A,B}
    input  wire logic [1:0] pair_i,
    // Phase lines
    output      logic       phase_a_o,
    output      logic       phase_b_o
);
    logic b_lag = 1'b0;

    initial phase_a_o = 1'b0;
    initial phase_b_o = 1'b0;

    // B lags A by a cycle: real phase outputs never switch together
    always @(posedge clk_i) begin
        phase_a_o <= pair_i[1];
        b_lag     <= pair_i[0];
        phase_b_o <= b_lag;
    end
endmodule : quad_encoder_model

// File: testbench/quad_decoder_sampler_tb_top.sv
// Self-checking bench for the quadrature decoder
`timescale 1ns/10ps
`include "quad_decoder_cfg.svh"
module quad_decoder_sampler_tb_top;
    import quad_decoder_pkg::*;
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] acc;
        logic [1:0]  pair;
    } row_type;
    // Sample seen, accumulator after it, pair shown next; all 16 transitions
    localparam row_type ROWS [17] = '{'{32'h0, 32'h0, 2'h0}, '{32'h0, 32'h0, 2'h1}, '{32'h1, 32'h1, 2'h1},
        '{32'h0, 32'h1, 2'h2}, '{32'h2, 32'h1, 2'h1}, '{32'h2, 32'h1, 2'h3}, '{32'h1, 32'h2, 2'h3},
        '{32'h0, 32'h2, 2'h2}, '{32'h1, 32'h3, 2'h2}, '{32'h0, 32'h3, 2'h0}, '{32'h1, 32'h4, 2'h2},
        '{32'hFFFFFFFF, 32'h3, 2'h3}, '{32'hFFFFFFFF, 32'h2, 2'h1}, '{32'hFFFFFFFF, 32'h1, 2'h0},
        '{32'hFFFFFFFF, 32'h0, 2'h3}, '{32'h2, 32'h0, 2'h0}, '{32'h2, 32'h0, 2'h0}};
    localparam logic [11:0] RST_A [6] = '{`QD_OFS_PERIOD, `QD_OFS_LEAD, `QD_OFS_POLARITY,
        `QD_OFS_ILLUM_SEL, `QD_OFS_STATUS, 12'h0FC};
    localparam logic [31:0] RST_V [6] = '{32'h80, 32'h10, 32'h1, 32'h1, 32'h0, 32'h0};

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        irq;
    logic        illum;
    logic        illum_oe_n;
    logic        ph_a;
    logic        ph_b;
    logic [1:0]  pair = 2'h0;
    logic [31:0] q;
    int          error_cnt = 0;
    int          checked = 0;
    int          cycles = 0;
    time         t_last;

    quad_decoder u_quad_decoder (
        .SYS_CLK_I         (clk),
        .NRST_I            (rst_n),
        .AVS_ADDRESS_I     (addr),
        .AVS_READ_I        (rd),
        .AVS_WRITE_I       (wr),
        .AVS_WRITEDATA_I   (wdata),
        .AVS_BYTEENABLE_I  (4'hF),
        .AVS_READDATA_O    (rdata),
        .AVS_WAITREQUEST_O (waitreq),
        .IRQ_O             (irq),
        .PHASE_A_I         (ph_a),
        .PHASE_B_I         (ph_b),
        .ILLUM_O           (illum),
        .ILLUM_OE_N_O      (illum_oe_n)
    );

    quad_encoder_model u_quad_encoder_model (
        .clk_i     (clk),
        .pair_i    (pair),
        .phase_a_o (ph_a),
        .phase_b_o (ph_b)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task final_report;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end
        else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // Request held until waitrequest is sampled low
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= w;
        rd    <= ~w;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task rdck(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q, e);
    endtask : rdck

    // Two edges first so a just-cleared interrupt has dropped
    task wait_irq;
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n == 1000) begin
            error_cnt++;
        end
    endtask : wait_irq

    // Ceiling well above the roughly 9200 cycles of the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt++;
            final_report();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rdck(RST_A[i], RST_V[i]);
        end
        check({30'h0, irq, illum_oe_n}, 32'h1);
        bus(1'b1, `QD_OFS_PERIOD, 32'h2);
        bus(1'b1, `QD_OFS_LEAD, 32'h1);
        bus(1'b1, `QD_OFS_MASK, 32'h1);
        bus(1'b1, `QD_OFS_ENABLE, 32'h1);
        bus(1'b1, `QD_OFS_START, 32'h1);
        for (int i = 0; i < 17; i++) begin
            wait_irq();
            if (i > 0) check(32'($time - t_last), 32'h000007D0);
            t_last = $time;
            rdck(`QD_OFS_SAMPLE, ROWS[i].val);
            rdck(`QD_OFS_ACC, ROWS[i].acc);
            bus(1'b1, `QD_OFS_STATUS, 32'h1);
            pair <= ROWS[i].pair;
        end
        rdck(`QD_OFS_DBL, 32'h4);
        bus(1'b1, `QD_OFS_CLR_BOTH, 32'h1);
        rdck(`QD_OFS_DBL_SNAP, 32'h4);
        rdck(`QD_OFS_DBL, 32'h0);
        // Restart on a different pair: first sample only primes
        bus(1'b1, `QD_OFS_STOP, 32'h1);
        // Double event stays set: only the ready bit was cleared
        rdck(`QD_OFS_STATUS, 32'hA);
        pair <= 2'h1;
        bus(1'b1, `QD_OFS_START, 32'h1);
        wait_irq();
        rdck(`QD_OFS_SAMPLE, 32'h0);
        rdck(`QD_OFS_ACC, 32'h0);
        bus(1'b1, `QD_OFS_STATUS, 32'h1);
        pair <= 2'h0;
        wait_irq();
        rdck(`QD_OFS_SAMPLE, 32'hFFFFFFFF);
        rdck(`QD_OFS_ACC, 32'hFFFFFFFF);
        bus(1'b1, `QD_OFS_CLR_ACC, 32'h1);
        rdck(`QD_OFS_ACC_SNAP, 32'hFFFFFFFF);
        rdck(`QD_OFS_ACC, 32'h0);
        bus(1'b1, `QD_OFS_STATUS, 32'h1);
        repeat (90) @(posedge clk);
        check({30'h0, illum, illum_oe_n}, 32'h0);
        repeat (200) @(posedge clk);
        check({30'h0, illum, illum_oe_n}, 32'h2);
        // Active-low illumination
        bus(1'b1, `QD_OFS_STOP, 32'h1);
        bus(1'b1, `QD_OFS_POLARITY, 32'h0);
        bus(1'b1, `QD_OFS_START, 32'h1);
        wait_irq();
        bus(1'b1, `QD_OFS_STATUS, 32'h1);
        repeat (90) @(posedge clk);
        check({30'h0, illum, illum_oe_n}, 32'h2);
        repeat (200) @(posedge clk);
        check({30'h0, illum, illum_oe_n}, 32'h0);
        // Disconnected pin, then masked ready event
        bus(1'b1, `QD_OFS_STOP, 32'h1);
        bus(1'b1, `QD_OFS_ILLUM_SEL, 32'h0);
        bus(1'b1, `QD_OFS_START, 32'h1);
        bus(1'b1, `QD_OFS_MASK, 32'h0);
        bus(1'b1, `QD_OFS_STATUS, 32'hF);
        repeat (450) @(posedge clk);
        check({30'h0, irq, illum_oe_n}, 32'h1);
        rdck(`QD_OFS_STATUS, 32'h1);
        bus(1'b1, `QD_OFS_STATUS, 32'h1);
        rdck(`QD_OFS_STATUS, 32'h0);
        final_report();
    end
endmodule : quad_decoder_sampler_tb_top
